// ---- hw/pvic_ctrl.sv ----
/*
 * Prioritized vector interrupt controller: request capture, priority
 * arbitration, current-priority mask with preemption stack, software
 * requests and a classic Wishbone register slave.
 * Assumes peripheral request lines are levels synchronous to clk_i and
 * that the core pulses cpu_ack_i for one cycle when it takes a vector.
 */
// Decided for this implementation: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
module pvic_ctrl #(
	parameter int N_PER = pvic_pkg::N_PER,
	parameter int LIFO_DEPTH = pvic_pkg::LIFO_DEPTH
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [N_PER-1:0] per_req_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic cpu_ack_i,
	output pvic_pkg::pvic_cpu_s cpu_o,
	output logic irq_o
);
	localparam int NV = pvic_pkg::N_SW + N_PER;
	localparam int PW = pvic_pkg::PRI_W;
	localparam int SPW = $clog2(LIFO_DEPTH + 1);

	// ---------------------------------------------------------------
	// Arbitration
	// ---------------------------------------------------------------
	function automatic pvic_pkg::pvic_best_s pick(input logic [NV-1:0] pend,
			input logic [PW-1:0] pri [NV]);
		pvic_pkg::pvic_best_s b;
		b = '0;
		for (int i = 0; i < NV; i++) begin
			// Strict compare keeps the lowest vector on ties
			if (pend[i] && pri[i] != '0 && (!b.found || pri[i] > b.pri)) begin
				b.found = 1'b1;
				b.pri = pri[i];
				b.vec = pvic_pkg::VEC_W'(i);
			end
		end
		return b;
	endfunction

	function automatic logic lane(input logic [3:0] sel, input int bitpos);
		return sel[bitpos / 8];
	endfunction

	logic [N_PER-1:0] per_q, per_d;
	logic [pvic_pkg::N_SW-1:0] sw_q, sw_d;
	logic [PW-1:0] pri_q [NV];
	logic [PW-1:0] pri_d [NV];
	logic [PW-1:0] cur_q, cur_d;
	logic [PW-1:0] stk_q [LIFO_DEPTH];
	logic [PW-1:0] stk_d [LIFO_DEPTH];
	logic [SPW-1:0] sp_q, sp_d;
	pvic_pkg::pvic_best_s best_q, best_d;
	pvic_pkg::pvic_cpu_s cpu_q, cpu_d;
	logic hwvec_q, hwvec_d;
	logic [7:0] psel_q, psel_d;
	logic [pvic_pkg::EVT_W-1:0] evt_q, evt_d, msk_q, msk_d;
	logic ack_q, ack_d;
	logic [31:0] rd_q, rd_d;
	logic irq_q, irq_d;

	logic acc, wr, rd, take, end_svc;
	logic [pvic_pkg::EVT_W-1:0] evt_set;

	// Access completes on the cycle ack is shown
	assign acc = wb_cyc_i && wb_stb_i && ack_q;
	assign wr = acc && wb_we_i;
	assign rd = acc && !wb_we_i;
	// Hardware mode takes the core's strobe, software mode the vector read
	assign take = hwvec_q ? cpu_ack_i : (rd && wb_adr_i == pvic_pkg::REG_VEC_ACK);
	assign end_svc = wr && wb_adr_i == pvic_pkg::REG_END_SVC;

	// ---------------------------------------------------------------
	// Request path: capture, pick, compare - one clock each
	// ---------------------------------------------------------------
	always_comb begin
		// External and wakeup groups arrive on fixed lines of this bus
		per_d = per_req_i;
		best_d = pick({per_q, sw_q}, pri_q);
		// Pending above the running priority raises the request
		irq_d = best_q.found && best_q.pri > cur_d;
		cpu_d.irq = irq_d;
		cpu_d.vec = best_q.found ? best_q.vec : cpu_q.vec;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			per_q <= '0;
			best_q <= '0;
			cpu_q <= '0;
		end else begin
			per_q <= per_d;
			best_q <= best_d;
			cpu_q <= cpu_d;
		end
	end

	assign cpu_o = cpu_q;

	// ---------------------------------------------------------------
	// Current priority and preemption stack
	// ---------------------------------------------------------------
	always_comb begin
		cur_d = cur_q;
		sp_d = sp_q;
		stk_d = stk_q;
		evt_set = '0;
		if (take && cpu_q.irq) begin
			evt_set[pvic_pkg::EVT_ACK_BIT] = 1'b1;
			if (sp_q == SPW'(LIFO_DEPTH)) begin
				evt_set[pvic_pkg::EVT_OVF_BIT] = 1'b1;
			end else begin
				stk_d[sp_q[SPW-2:0]] = cur_q;
				sp_d = sp_q + SPW'(1);
			end
			cur_d = best_q.pri;
		end else if (end_svc) begin
			if (sp_q == '0) begin
				evt_set[pvic_pkg::EVT_UNF_BIT] = 1'b1;
			end else begin
				sp_d = sp_q - SPW'(1);
				cur_d = stk_q[sp_d[SPW-2:0]];
			end
		end else if (wr && wb_adr_i == pvic_pkg::REG_CUR_PRI && wb_sel_i[0]) begin
			// Raising this blocks equal-ceiling tasks from preempting
			cur_d = wb_dat_i[PW-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cur_q <= pvic_pkg::CUR_PRI_RST;
			sp_q <= '0;
			for (int i = 0; i < LIFO_DEPTH; i++) begin
				stk_q[i] <= pvic_pkg::CUR_PRI_RST;
			end
		end else begin
			cur_q <= cur_d;
			sp_q <= sp_d;
			stk_q <= stk_d;
		end
	end

	// ---------------------------------------------------------------
	// Software registers
	// ---------------------------------------------------------------
	always_comb begin
		sw_d = sw_q;
		pri_d = pri_q;
		hwvec_d = hwvec_q;
		psel_d = psel_q;
		msk_d = msk_q;
		evt_d = evt_q;
		if (wr) begin
			case (wb_adr_i)
				pvic_pkg::REG_CTRL: begin
					if (wb_sel_i[0]) begin
						hwvec_d = wb_dat_i[pvic_pkg::CTRL_HWVEC_BIT];
					end
				end
				pvic_pkg::REG_SW_REQ: begin
					// Set in low byte, clear in next; set wins
					if (lane(wb_sel_i, pvic_pkg::SW_CLR_LSB)) begin
						sw_d = sw_d & ~wb_dat_i[pvic_pkg::SW_CLR_LSB +: pvic_pkg::N_SW];
					end
					if (wb_sel_i[0]) begin
						sw_d = sw_d | wb_dat_i[pvic_pkg::N_SW-1:0];
					end
				end
				pvic_pkg::REG_PRI_SEL: begin
					if (wb_sel_i[0]) begin
						psel_d = wb_dat_i[7:0];
					end
				end
				pvic_pkg::REG_PRI_VAL: begin
					if (wb_sel_i[0] && psel_q < 8'(NV)) begin
						pri_d[psel_q] = wb_dat_i[PW-1:0];
					end
				end
				pvic_pkg::REG_EVT_MASK: begin
					if (wb_sel_i[0]) begin
						msk_d = wb_dat_i[pvic_pkg::EVT_W-1:0];
					end
				end
				pvic_pkg::REG_EVT_STAT: begin
					if (wb_sel_i[0]) begin
						evt_d = evt_q & ~wb_dat_i[pvic_pkg::EVT_W-1:0];
					end
				end
				default: begin
				end
			endcase
		end
		// New events beat a same-cycle clear
		evt_d = evt_d | evt_set;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sw_q <= '0;
			hwvec_q <= pvic_pkg::CTRL_RST[pvic_pkg::CTRL_HWVEC_BIT];
			psel_q <= '0;
			msk_q <= '0;
			evt_q <= '0;
			for (int i = 0; i < NV; i++) begin
				pri_q[i] <= pvic_pkg::PRI_RST;
			end
		end else begin
			sw_q <= sw_d;
			hwvec_q <= hwvec_d;
			psel_q <= psel_d;
			msk_q <= msk_d;
			evt_q <= evt_d;
			pri_q <= pri_d;
		end
	end

	// ---------------------------------------------------------------
	// Wishbone answer: ack one clock after the strobe, data registered
	// ---------------------------------------------------------------
	always_comb begin
		ack_d = wb_cyc_i && wb_stb_i && !ack_q;
		rd_d = '0;
		case (wb_adr_i)
			pvic_pkg::REG_CTRL: rd_d[pvic_pkg::CTRL_HWVEC_BIT] = hwvec_q;
			pvic_pkg::REG_CUR_PRI: rd_d[PW-1:0] = cur_q;
			// Vector with its priority; in software mode reading it is the acknowledge
			pvic_pkg::REG_VEC_ACK: rd_d = {15'h0000, cpu_q.irq, 3'h0, best_q.pri,
				cpu_q.vec};
			pvic_pkg::REG_SW_REQ: rd_d[pvic_pkg::N_SW-1:0] = sw_q;
			pvic_pkg::REG_PRI_SEL: rd_d[7:0] = psel_q;
			pvic_pkg::REG_PRI_VAL: rd_d[PW-1:0] = (psel_q < 8'(NV)) ? pri_q[psel_q] : '0;
			pvic_pkg::REG_EVT_STAT: rd_d[pvic_pkg::EVT_W-1:0] = evt_q;
			pvic_pkg::REG_EVT_MASK: rd_d[pvic_pkg::EVT_W-1:0] = msk_q;
			pvic_pkg::REG_LIFO_LVL: rd_d[SPW-1:0] = sp_q;
			default: rd_d = '0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			rd_q <= '0;
			irq_q <= 1'b0;
		end else begin
			ack_q <= ack_d;
			rd_q <= rd_d;
			irq_q <= |(evt_d & msk_q);
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rd_q;
	assign irq_o = irq_q;
endmodule

// ---- hw/pvic_pkg.sv ----
/*
 * Constants, register map and carrier types of the prioritized vector
 * interrupt controller. Assumes a 32-bit classic Wishbone register bus.
 */
// Operation
// - Accept 148 vectors: 140 peripheral, 8 software
// - External groups occupy fixed peripheral vector slots
// - Each source owns a unique 9-bit vector
// - Per-source writable priority, sixteen levels
// - Higher pending priority preempts running work
// - Push preempted priority on acknowledge, pop at end
// - Current priority is a software-writable mask
// - Eight software set/clear request bits
// - Vector delivered by hardware or register read
// - Request reaches processor within three clocks
package pvic_pkg;
	localparam int N_SW = 8;
	localparam int N_PER = 140;
	localparam int N_VEC = 148;
	localparam int VEC_W = 9;
	localparam int PRI_W = 4;
	localparam int LIFO_DEPTH = 16;
	// ---------------------------------------------------------------
	// Vector layout: software first, peripherals from N_SW upward
	// ---------------------------------------------------------------
	localparam int SW_BASE = 0;
	localparam int PER_BASE = 8;
	localparam int EXT16_VEC0 = 41;
	localparam int EXT16_NUM = 2;
	localparam int WKUP_VEC0 = 46;
	localparam int WKUP_NUM = 3;
	// ---------------------------------------------------------------
	// Register byte offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_CUR_PRI = 8'h04;
	localparam logic [7:0] REG_VEC_ACK = 8'h08;
	localparam logic [7:0] REG_END_SVC = 8'h0c;
	localparam logic [7:0] REG_SW_REQ = 8'h10;
	localparam logic [7:0] REG_PRI_SEL = 8'h14;
	localparam logic [7:0] REG_PRI_VAL = 8'h18;
	localparam logic [7:0] REG_EVT_STAT = 8'h1c;
	localparam logic [7:0] REG_EVT_MASK = 8'h20;
	localparam logic [7:0] REG_LIFO_LVL = 8'h24;
	// ---------------------------------------------------------------
	// Field positions and reset values
	// ---------------------------------------------------------------
	localparam int CTRL_HWVEC_BIT = 0;
	localparam int SW_CLR_LSB = 8;
	localparam int EVT_ACK_BIT = 0;
	localparam int EVT_OVF_BIT = 1;
	localparam int EVT_UNF_BIT = 2;
	localparam int EVT_W = 3;
	localparam logic [PRI_W-1:0] CUR_PRI_RST = 4'h0;
	localparam logic [PRI_W-1:0] PRI_RST = 4'h0;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam int REQ_LATENCY_CLK = 3;

	typedef struct packed {
		logic irq;
		logic [VEC_W-1:0] vec;
	} pvic_cpu_s;

	typedef struct packed {
		logic found;
		logic [PRI_W-1:0] pri;
		logic [VEC_W-1:0] vec;
	} pvic_best_s;
endpackage

// ---- verif/pvic_core_model.sv ----
/* Core side model: takes the presented vector in hardware mode.
   Expects the registered request of pvic_ctrl. */
`timescale 1ns/1ps
module pvic_core_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic hw_i,
	input wire logic irq_i,
	output logic ack_o
);
	logic [1:0] gap_q;
	// Gap after a take, since the request may stand a cycle longer
	always_ff @(posedge clk_i) begin
		if (rst_i || !hw_i) begin
			ack_o <= 1'b0;
			gap_q <= 2'h0;
		end else begin
			ack_o <= irq_i && gap_q == 2'h0 && !ack_o;
			gap_q <= ack_o ? 2'h3 : gap_q - {1'b0, gap_q != 2'h0};
		end
	end
endmodule

// ---- verif/pvic_monitor.sv ----
/* Port checker for pvic_ctrl.
   Bound to the design from the testbench top file. */
`timescale 1ns/1ps
module pvic_monitor #(
	parameter int N_PER = 140
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [N_PER-1:0] per_req_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic cpu_ack_i,
	input wire pvic_pkg::pvic_cpu_s cpu_o,
	input wire logic irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("bus ack too long");
	ack_time_a: assert property (wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus ack late");
	ack_cause_a: assert property (!wb_stb_i |=> !wb_ack_o)
		else $error("bus ack without request");
	vec_range_a: assert property (cpu_o.irq |-> cpu_o.vec < 9'h094)
		else $error("vector out of range");
	quiet_hold_a: assert property (
		(!wb_stb_i && !cpu_ack_i && $stable(per_req_i))[*6] |-> $stable(cpu_o) && $stable(irq_o))
		else $error("core request moved with no cause");
	evt_rise_a: assert property ($rose(irq_o) |-> $past(cpu_ack_i) || $past(cpu_ack_i, 2)
		|| $past(wb_ack_o) || $past(wb_ack_o, 2))
		else $error("event line rose with no cause");
	evt_fall_a: assert property ($fell(irq_o) |-> $past(wb_ack_o) || $past(wb_ack_o, 2))
		else $error("event line fell with no write");
	reset_out_a: assert property ($fell(rst_i) |-> !cpu_o.irq && !irq_o && !wb_ack_o)
		else $error("outputs not idle after reset");
endmodule

// ---- verif/testbench.sv ----
/* Self-checking bench for pvic_ctrl over classic Wishbone.
   Assumes pvic_pkg and the core model are compiled first. */
`timescale 1ns/1ps
`define CHK(nm, ex, ac) begin n_tests++; if ((ac) !== (ex)) begin errors++; \
	$display("[FAIL] %s exp %h got %h", nm, ex, ac); end end
module testbench;
	logic clk_i, rst_i, cyc, stb, we, hw, cack, irq_o, wb_ack_o;
	logic [7:0] adr;
	logic [31:0] wdat, rq, wb_dat_o;
	logic [139:0] per_req;
	pvic_pkg::pvic_cpu_s cpu_o;
	int errors = 0, n_tests = 0, cyc_cnt = 0;
	pvic_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .per_req_i(per_req), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cpu_ack_i(cack), .cpu_o(cpu_o),
		.irq_o(irq_o));
	pvic_core_model core (.clk_i(clk_i), .rst_i(rst_i), .hw_i(hw), .irq_i(cpu_o.irq),
		.ack_o(cack));
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc_cnt++;
		if (cyc_cnt == 5000) begin
			errors++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("errors %0d tests %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rq = wb_dat_o;
		cyc <= 1'b0; stb <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		`CHK($sformatf("reg %h", a), e, rq)
	endtask
	task automatic wirq();
		for (int i = 0; i < 20; i++) begin
			@(posedge clk_i); #1;
			if (cpu_o.irq === 1'b1) break;
		end
	endtask
	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00;
		wdat = 32'h0; per_req = '0; hw = 1'b0;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		bus(1'b1, pvic_pkg::REG_PRI_SEL, 32'hd); bus(1'b1, pvic_pkg::REG_PRI_VAL, 32'h3);
		bus(1'b1, pvic_pkg::REG_PRI_SEL, 32'ha); bus(1'b1, pvic_pkg::REG_PRI_VAL, 32'h3);
		rchk(pvic_pkg::REG_PRI_VAL, 32'h3);
		@(posedge clk_i); per_req <= 140'h20;
		repeat (3) @(posedge clk_i); #1;
		`CHK("irq", 1'b1, cpu_o.irq)
		`CHK("vec", 9'h00d, cpu_o.vec)
		rchk(pvic_pkg::REG_VEC_ACK, 32'h0001_060d);
		rchk(pvic_pkg::REG_LIFO_LVL, 32'h1);
		`CHK("irq", 1'b0, cpu_o.irq)
		@(posedge clk_i); per_req <= 140'h24;
		repeat (5) @(posedge clk_i); #1;
		`CHK("irq", 1'b0, cpu_o.irq)
		rchk(pvic_pkg::REG_EVT_STAT, 32'h1);
		`CHK("irq_o", 1'b0, irq_o)
		bus(1'b1, pvic_pkg::REG_EVT_MASK, 32'h1);
		repeat (2) @(posedge clk_i); #1;
		`CHK("irq_o", 1'b1, irq_o)
		bus(1'b1, pvic_pkg::REG_EVT_STAT, 32'h1);
		repeat (2) @(posedge clk_i); #1;
		`CHK("irq_o", 1'b0, irq_o)
		bus(1'b1, pvic_pkg::REG_PRI_SEL, 32'h1); bus(1'b1, pvic_pkg::REG_PRI_VAL, 32'h5);
		bus(1'b1, pvic_pkg::REG_CTRL, 32'h1); hw <= 1'b1;
		bus(1'b1, pvic_pkg::REG_SW_REQ, 32'h2);
		wirq();
		`CHK("vec", 9'h001, cpu_o.vec)
		repeat (3) @(posedge clk_i);
		rchk(pvic_pkg::REG_CUR_PRI, 32'h5);
		rchk(pvic_pkg::REG_LIFO_LVL, 32'h2);
		bus(1'b1, pvic_pkg::REG_SW_REQ, 32'h200);
		rchk(pvic_pkg::REG_SW_REQ, 32'h0);
		bus(1'b1, pvic_pkg::REG_CTRL, 32'h0); hw <= 1'b0;
		bus(1'b1, pvic_pkg::REG_END_SVC, 32'h0);
		rchk(pvic_pkg::REG_CUR_PRI, 32'h3);
		bus(1'b1, pvic_pkg::REG_END_SVC, 32'h0);
		wirq();
		`CHK("vec", 9'h00a, cpu_o.vec)
		bus(1'b1, pvic_pkg::REG_CUR_PRI, 32'h3);
		repeat (3) @(posedge clk_i); #1;
		`CHK("irq", 1'b0, cpu_o.irq)
		bus(1'b1, pvic_pkg::REG_END_SVC, 32'h0);
		rchk(pvic_pkg::REG_EVT_STAT, 32'h5);
		// Top peripheral line reaches the last vector
		bus(1'b1, pvic_pkg::REG_PRI_SEL, 32'h93); bus(1'b1, pvic_pkg::REG_PRI_VAL, 32'h9);
		@(posedge clk_i); per_req <= {1'b1, 139'h0};
		repeat (3) @(posedge clk_i); #1;
		`CHK("irq", 1'b1, cpu_o.irq)
		`CHK("vec", 9'h093, cpu_o.vec)
		rchk(8'hf0, 32'h0);
		end_sim();
	end
endmodule
bind pvic_ctrl pvic_monitor #(.N_PER(N_PER)) mon (.clk_i(clk_i), .rst_i(rst_i),
	.per_req_i(per_req_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
	.cpu_ack_i(cpu_ack_i), .cpu_o(cpu_o), .irq_o(irq_o));
